//--- bcc_boost_ctrl.sv
// Overview of operation
// - skip whole pulse below minimum width
// - latch cell mode from strap at power-on
// - two-cell mode keeps converter always off
// - one-cell: off in sleep, on otherwise
// - cell mode changes only at power-on reset
// - config bit 0 selects oscillator or system clock
// - internal oscillator runs near 2.4 MHz
// - bits 6:5 divide system clock for converter
// - config bit 3 inverts divider output clock
// - sleep disables converter, rail tied to battery
// - float bit leaves rail open in sleep
// - reset values work without software setup
// - divider codes mean divide by 2,4,8,16
// - divider ignored when oscillator is selected
// - minimum width codes: none,20,40,80 ns
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
`default_nettype none
module bcc_boost_ctrl
    import bcc_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic por_n_i,
    input wire logic converter_strap_pin_i,
    input wire logic sleep_mode_i,
    input wire logic [7:0] duty_demand_i,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic converter_enable_o,
    output logic converter_clock_o,
    output logic switch_drive_o,
    output logic pulse_skipped_o,
    output logic rail_tie_battery_o,
    output logic [2:0] target_voltage_sel_o,
    output logic switch_size_select_o,
    output logic peak_current_limit_o,
    output logic adc_sync_enable_o,
    output logic adc_clock_invert_o
);
    bcc_clk_if cif ();

    logic [7:0] converter_control_reg;
    logic [7:0] converter_config_reg;
    logic [15:0] skip_count;
    logic one_cell_mode;
    logic strap_taken;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic write_fire;
    logic read_fire;
    logic [7:0] on_cnt;
    logic [7:0] min_cycles;
    logic skip_now;

    // ---------------------------------------------------------------
    // cell mode strap, touched only by the power-on reset
    // ---------------------------------------------------------------
    // the strap is caught on the first edge after power-on release;
    // the ordinary reset does not reach these flops, so it cannot
    // flip the mode of a running supply
    always_ff @(posedge clk_sys_i or negedge por_n_i) begin
        if (!por_n_i) begin
            one_cell_mode <= 1'b0;
            strap_taken <= 1'b0;
        end else if (!strap_taken) begin
            one_cell_mode <= converter_strap_pin_i;
            strap_taken <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // enable and sleep rail control
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            converter_enable_o <= 1'b0;
            rail_tie_battery_o <= 1'b0;
        end else begin
            converter_enable_o <= strap_taken && one_cell_mode && !sleep_mode_i;
            rail_tie_battery_o <= sleep_mode_i
                && !converter_config_reg[CFG_FLOAT_BIT];
        end
    end

    // ---------------------------------------------------------------
    // AXI4-Lite write channel
    // ---------------------------------------------------------------
    assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
    assign s_axi_wready_o = !w_held && !s_axi_bvalid_o;
    assign write_fire = aw_held && w_held && !s_axi_bvalid_o;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
            end
            if (write_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= (aw_addr[7:2] == ADDR_CTRL[7:2]
                    || aw_addr[7:2] == ADDR_CFG[7:2]) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // configuration registers
    // ---------------------------------------------------------------
    // the reset values give a working converter with no software setup
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            converter_control_reg <= CTRL_RESET;
            converter_config_reg <= CFG_RESET;
        end else if (write_fire && w_strb[0]) begin
            if (aw_addr[7:2] == ADDR_CTRL[7:2]) begin
                converter_control_reg <= w_data[7:0];
            end
            if (aw_addr[7:2] == ADDR_CFG[7:2]) begin
                converter_config_reg <= w_data[7:0] & CFG_WMASK;
            end
        end
    end

    assign cif.sel_sys = converter_config_reg[CFG_SRC_BIT];
    assign cif.invert = converter_config_reg[CFG_INV_BIT];
    assign cif.divider = converter_config_reg[CFG_DIV_LSB +: 2];
    assign target_voltage_sel_o = converter_control_reg[CTRL_VSEL_LSB +: 3];
    assign switch_size_select_o = converter_control_reg[CTRL_SWITCH_SIZE_SELECT_BIT];
    assign adc_sync_enable_o = converter_control_reg[CTRL_SYNC_BIT];
    assign peak_current_limit_o = converter_config_reg[CFG_ILIM_BIT];
    assign adc_clock_invert_o = converter_config_reg[CFG_ADCINV_BIT];

    // ---------------------------------------------------------------
    // AXI4-Lite read channel
    // ---------------------------------------------------------------
    assign s_axi_arready_o = !s_axi_rvalid_o;
    assign read_fire = s_axi_arvalid_i && s_axi_arready_o;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= RESP_OKAY;
        end else if (read_fire) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o <= RESP_OKAY;
            s_axi_rdata_o <= 32'h0000_0000;
            unique case (s_axi_araddr_i[7:2])
                ADDR_CTRL[7:2]: s_axi_rdata_o[7:0] <= converter_control_reg;
                ADDR_CFG[7:2]: s_axi_rdata_o[7:0] <= converter_config_reg;
                ADDR_STAT[7:2]: begin
                    s_axi_rdata_o[STAT_ONECELL_BIT] <= one_cell_mode;
                    s_axi_rdata_o[STAT_EN_BIT] <= converter_enable_o;
                    s_axi_rdata_o[STAT_SYS_BIT] <= cif.sys_active;
                    s_axi_rdata_o[STAT_TIE_BIT] <= rail_tie_battery_o;
                end
                ADDR_SKIP[7:2]: s_axi_rdata_o[15:0] <= skip_count;
                default: s_axi_rresp_o <= RESP_SLVERR;
            endcase
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // switching clock
    // ---------------------------------------------------------------
    bcc_clk_gen u_clk_gen (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .cif(cif.gen)
    );

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            converter_clock_o <= 1'b0;
        end else begin
            converter_clock_o <= cif.conv_clk && converter_enable_o;
        end
    end

    // ---------------------------------------------------------------
    // pulse width and pulse skipping
    // ---------------------------------------------------------------
    // the demand is the on-time in system clock cycles, taken at each
    // rising edge of the switching clock; a demand below the minimum
    // drops the whole pulse rather than emitting a short one
    assign min_cycles = bcc_mpw_cycles(converter_control_reg[CTRL_MPW_LSB +: 2]);
    assign skip_now = cif.conv_rise && converter_enable_o
        && (duty_demand_i < min_cycles);

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            switch_drive_o <= 1'b0;
            on_cnt <= 8'h00;
        end else if (!converter_enable_o || skip_now) begin
            switch_drive_o <= 1'b0;
            on_cnt <= 8'h00;
        end else if (cif.conv_rise && duty_demand_i != 8'h00) begin
            switch_drive_o <= 1'b1;
            on_cnt <= duty_demand_i;
        end else if (on_cnt > 8'h01) begin
            on_cnt <= on_cnt - 8'h01;
        end else begin
            switch_drive_o <= 1'b0;
            on_cnt <= 8'h00;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pulse_skipped_o <= 1'b0;
            skip_count <= 16'h0000;
        end else begin
            pulse_skipped_o <= skip_now;
            if (skip_now && skip_count != 16'hFFFF) begin
                skip_count <= skip_count + 16'h0001;
            end
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_skip_whole_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        skip_now |=> !switch_drive_o && pulse_skipped_o)
        else $error("short pulse not skipped");
    a_pulse_full_width: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        cif.conv_rise && converter_enable_o && !skip_now && duty_demand_i == 8'h05
        ##1 converter_enable_o && !cif.conv_rise [*4] |-> switch_drive_o)
        else $error("pulse ended before its demanded width");
    a_strap_capture: assert property (@(posedge clk_sys_i) disable iff (!por_n_i)
        por_n_i && !strap_taken |=> strap_taken && one_cell_mode == $past(converter_strap_pin_i))
        else $error("strap not latched after power-on");
    a_cell_mode_held: assert property (@(posedge clk_sys_i) disable iff (!por_n_i)
        strap_taken |=> $stable(one_cell_mode))
        else $error("cell mode changed outside power-on");
    a_two_cell_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        strap_taken && !one_cell_mode |=> !converter_enable_o)
        else $error("converter enabled in two-cell mode");
    a_one_cell_en: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        rst_n_i && strap_taken && one_cell_mode |=> converter_enable_o == !$past(sleep_mode_i))
        else $error("one-cell enable does not follow sleep");
    a_sleep_rail_tie: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        rst_n_i && sleep_mode_i && !converter_config_reg[CFG_FLOAT_BIT]
        |=> rail_tie_battery_o && !converter_enable_o)
        else $error("rail not tied to battery in sleep");
    a_sleep_rail_float: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        converter_config_reg[CFG_FLOAT_BIT] |=> !rail_tie_battery_o)
        else $error("rail tied although float selected");
    a_src_select: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(cif.sys_active) |-> converter_config_reg[CFG_SRC_BIT])
        else $error("system clock path active while not selected");
endmodule
`default_nettype wire

//--- bcc_pkg.sv
`default_nettype none
package bcc_pkg;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int CLK_FREQ_KHZ = 250000;
    localparam int OSC_FREQ_KHZ = 2400;
    localparam int OSC_HALF_CYC = CLK_FREQ_KHZ / (2 * OSC_FREQ_KHZ);
    localparam int MPW1_NS = 20;
    localparam int MPW2_NS = 40;
    localparam int MPW3_NS = 80;
    localparam int MPW1_CYC = (MPW1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MPW2_CYC = (MPW2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MPW3_CYC = (MPW3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CFG = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_SKIP = 8'h0C;
    localparam int CTRL_MPW_LSB = 6;
    localparam int CTRL_SWITCH_SIZE_SELECT_BIT = 5;
    localparam int CTRL_SYNC_BIT = 3;
    localparam int CTRL_VSEL_LSB = 0;
    localparam int CFG_DIV_LSB = 5;
    localparam int CFG_ADCINV_BIT = 4;
    localparam int CFG_INV_BIT = 3;
    localparam int CFG_ILIM_BIT = 2;
    localparam int CFG_FLOAT_BIT = 1;
    localparam int CFG_SRC_BIT = 0;
    localparam int STAT_ONECELL_BIT = 0;
    localparam int STAT_EN_BIT = 1;
    localparam int STAT_SYS_BIT = 2;
    localparam int STAT_TIE_BIT = 3;
    localparam logic [7:0] CTRL_RESET = 8'h21;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] CFG_WMASK = 8'h7F;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MUX_OSC = 2'b00,
        MUX_TO_SYS = 2'b01,
        MUX_SYS = 2'b11,
        MUX_TO_OSC = 2'b10
    } bcc_mux_state_t;

    // minimum on-time in system clock cycles, zero for no minimum
    function automatic logic [7:0] bcc_mpw_cycles(input logic [1:0] code);
        unique case (code)
            2'h0: bcc_mpw_cycles = 8'h00;
            2'h1: bcc_mpw_cycles = 8'(MPW1_CYC);
            2'h2: bcc_mpw_cycles = 8'(MPW2_CYC);
            2'h3: bcc_mpw_cycles = 8'(MPW3_CYC);
        endcase
    endfunction

    // half period of the divided clock in system clock cycles: 1, 2, 4, 8
    function automatic logic [3:0] bcc_div_half(input logic [1:0] code);
        bcc_div_half = 4'h1 << code;
    endfunction
endpackage
`default_nettype wire

//--- bcc_clk_if.sv
`default_nettype none
interface bcc_clk_if;
    logic sel_sys;
    logic invert;
    logic [1:0] divider;
    logic conv_clk;
    logic conv_rise;
    logic sys_active;
    modport gen (input sel_sys, input invert, input divider,
                 output conv_clk, output conv_rise, output sys_active);
    modport ctl (output sel_sys, output invert, output divider,
                 input conv_clk, input conv_rise, input sys_active);
endinterface
`default_nettype wire

//--- bcc_clk_gen.sv
`default_nettype none
module bcc_clk_gen
    import bcc_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    bcc_clk_if.gen cif
);
    logic [5:0] osc_cnt;
    logic osc_lvl;
    logic [3:0] sys_cnt;
    logic sys_lvl;
    logic sys_src;
    logic conv_q;
    bcc_mux_state_t mux_state;

    // ---------------------------------------------------------------
    // local oscillator, about 2.4 MHz
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            osc_cnt <= 6'h00;
            osc_lvl <= 1'b0;
        end else if (osc_cnt == 6'(OSC_HALF_CYC - 1)) begin
            osc_cnt <= 6'h00;
            osc_lvl <= ~osc_lvl;
        end else begin
            osc_cnt <= osc_cnt + 6'h01;
        end
    end

    // ---------------------------------------------------------------
    // system clock path: divider then optional inversion
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sys_cnt <= 4'h0;
            sys_lvl <= 1'b0;
        end else if (sys_cnt >= bcc_div_half(cif.divider) - 4'h1) begin
            sys_cnt <= 4'h0;
            sys_lvl <= ~sys_lvl;
        end else begin
            sys_cnt <= sys_cnt + 4'h1;
        end
    end

    assign sys_src = sys_lvl ^ cif.invert;

    // ---------------------------------------------------------------
    // glitch-free source switch
    // ---------------------------------------------------------------
    // the output is parked low until the new source is low, so no runt
    // high phase can appear whatever the phase relation of the sources
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mux_state <= MUX_OSC;
        end else begin
            unique case (mux_state)
                MUX_OSC: if (cif.sel_sys && !osc_lvl) mux_state <= MUX_TO_SYS;
                MUX_TO_SYS: if (!sys_src) mux_state <= MUX_SYS;
                MUX_SYS: if (!cif.sel_sys && !sys_src) mux_state <= MUX_TO_OSC;
                MUX_TO_OSC: if (!osc_lvl) mux_state <= MUX_OSC;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cif.conv_clk <= 1'b0;
            conv_q <= 1'b0;
        end else begin
            unique case (mux_state)
                MUX_OSC: cif.conv_clk <= osc_lvl;
                MUX_SYS: cif.conv_clk <= sys_src;
                MUX_TO_SYS, MUX_TO_OSC: cif.conv_clk <= 1'b0;
            endcase
            conv_q <= cif.conv_clk;
        end
    end

    assign cif.conv_rise = cif.conv_clk & ~conv_q;
    assign cif.sys_active = (mux_state == MUX_SYS);

    a_osc_half_period: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $changed(osc_lvl) |-> $past(osc_cnt) == 6'(OSC_HALF_CYC - 1))
        else $error("oscillator half period wrong");
    a_mux_no_runt: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (mux_state == MUX_TO_SYS || mux_state == MUX_TO_OSC) |=> !cif.conv_clk)
        else $error("converter clock high while switching source");
    a_osc_ignores_div: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        mux_state == MUX_OSC |=> cif.conv_clk == $past(osc_lvl))
        else $error("converter clock does not follow oscillator");
    a_sys_path_invert: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        mux_state == MUX_SYS |=> cif.conv_clk == ($past(sys_lvl) ^ $past(cif.invert)))
        else $error("system clock path not inverted as selected");
endmodule
`default_nettype wire

//--- bcc_boost_ctrl_tb_top.sv
`default_nettype none
module bcc_boost_ctrl_tb_top import bcc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic clk_sys_i = 1'h0, rst_n_i = 1'h0, por_n_i = 1'h0;
    logic converter_strap_pin_i = 1'h1, sleep_mode_i = 1'h0;
    logic [7:0] duty_demand_i = 8'h00, s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
    logic [31:0] s_axi_wdata_i = 32'h0;
    logic [3:0] s_axi_wstrb_i = 4'hF;
    logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_arvalid_i = 1'h0;
    // ready held high: the master always accepts an answer at once
    logic s_axi_bready_i = 1'h1, s_axi_rready_i = 1'h1;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic [31:0] s_axi_rdata_o;
    logic converter_enable_o, converter_clock_o, switch_drive_o, pulse_skipped_o;
    logic rail_tie_battery_o, switch_size_select_o, peak_current_limit_o;
    logic adc_sync_enable_o, adc_clock_invert_o;
    logic [2:0] target_voltage_sel_o;
    int n_errors = 0, tests_run = 0;
    int p, w, e;
    logic s;
    logic [1:0] r;
    logic [31:0] q;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [1:0] wr; logic [1:0] rr;
        logic [31:0] q;} bcc_row_t;
    bcc_row_t rows [4] = '{'{ADDR_CTRL, 8'hD5, RESP_OKAY, RESP_OKAY, 32'hD5},
        '{ADDR_CFG, 8'hFE, RESP_OKAY, RESP_OKAY, 32'h7E},
        '{ADDR_STAT, 8'h00, RESP_SLVERR, RESP_OKAY, 32'h3},
        '{8'h10, 8'h55, RESP_SLVERR, RESP_SLVERR, 32'h0}};

    bcc_boost_ctrl dut_u (.clk_sys_i, .rst_n_i, .por_n_i, .converter_strap_pin_i,
        .sleep_mode_i, .duty_demand_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
        .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
        .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
        .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
        .converter_enable_o, .converter_clock_o, .switch_drive_o, .pulse_skipped_o,
        .rail_tie_battery_o, .target_voltage_sel_o, .switch_size_select_o,
        .peak_current_limit_o, .adc_sync_enable_o, .adc_clock_invert_o);

    initial begin
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d, errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic axw(input logic [7:0] a, input logic [7:0] d, output logic [1:0] rs);
        logic ap, wp, ta, tw;
        ap = 1'h1;
        wp = 1'h1;
        @(posedge clk_sys_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= {24'h0, d};
        s_axi_awvalid_i <= 1'h1;
        s_axi_wvalid_i <= 1'h1;
        while (ap || wp) begin
            @(negedge clk_sys_i);
            ta = ap && s_axi_awready_o === 1'h1;
            tw = wp && s_axi_wready_o === 1'h1;
            @(posedge clk_sys_i);
            if (ta) s_axi_awvalid_i <= 1'h0;
            if (tw) s_axi_wvalid_i <= 1'h0;
            ap = ap && !ta;
            wp = wp && !tw;
        end
        do @(negedge clk_sys_i); while (s_axi_bvalid_o !== 1'h1);
        rs = s_axi_bresp_o;
        @(posedge clk_sys_i);
    endtask

    task automatic axr(input logic [7:0] a, output logic [1:0] rs, output logic [31:0] d);
        logic ta;
        @(posedge clk_sys_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'h1;
        do begin
            @(negedge clk_sys_i);
            ta = s_axi_arready_o;
            @(posedge clk_sys_i);
        end while (ta !== 1'h1);
        s_axi_arvalid_i <= 1'h0;
        do @(negedge clk_sys_i); while (s_axi_rvalid_o !== 1'h1);
        rs = s_axi_rresp_o;
        d = s_axi_rdata_o;
        @(posedge clk_sys_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] rs;
        axw(a, d, rs);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ex);
        logic [1:0] rs;
        logic [31:0] d;
        axr(a, rs, d);
        chk(d, ex);
    endtask

    // caller sits just after a rising edge; por also clears the strap latch
    task automatic resets(input logic por);
        rst_n_i <= 1'h0;
        if (por) por_n_i <= 1'h0;
        repeat (3) @(posedge clk_sys_i);
        rst_n_i <= 1'h1;
        por_n_i <= 1'h1;
        repeat (6) @(negedge clk_sys_i);
        @(posedge clk_sys_i);
    endtask

    // one full period from rising edge to rising edge, in system cycles
    task automatic period(output int n);
        do @(negedge clk_sys_i); while (converter_clock_o !== 1'h0);
        do @(negedge clk_sys_i); while (converter_clock_o !== 1'h1);
        n = 0;
        do begin
            @(negedge clk_sys_i);
            n++;
        end while (converter_clock_o !== 1'h0);
        do begin
            @(negedge clk_sys_i);
            n++;
        end while (converter_clock_o !== 1'h1);
    endtask

    // settle one period, then longest drive run and any skip over two periods
    task automatic pulse(input logic [7:0] d, output int wd, output logic sk);
        int run;
        @(posedge clk_sys_i);
        duty_demand_i <= d;
        repeat (120) @(negedge clk_sys_i);
        wd = 0;
        run = 0;
        sk = 1'h0;
        repeat (220) begin
            @(negedge clk_sys_i);
            run = (switch_drive_o === 1'h1) ? run + 1 : 0;
            if (run > wd) wd = run;
            if (pulse_skipped_o === 1'h1) sk = 1'h1;
        end
        @(posedge clk_sys_i);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        resets(1'h1);
        chk(32'(target_voltage_sel_o), 32'h1);
        chk(32'(converter_enable_o), 32'h1);
        rd(ADDR_CTRL, 32'h21);
        rd(ADDR_CFG, 32'h0);
        rd(ADDR_STAT, 32'h3);
        foreach (rows[i]) begin
            axw(rows[i].a, rows[i].d, r);
            chk(32'(r), 32'(rows[i].wr));
            axr(rows[i].a, r, q);
            chk(32'(r), 32'(rows[i].rr));
            chk(q, rows[i].q);
        end
        chk(32'({switch_size_select_o, peak_current_limit_o, adc_clock_invert_o}), 32'h3);
        wr(ADDR_CTRL, 8'h29);
        chk(32'({target_voltage_sel_o, switch_size_select_o, adc_sync_enable_o}), 32'h7);
        wr(ADDR_CFG, 8'h00);
        sleep_mode_i <= 1'h1;
        repeat (4) @(negedge clk_sys_i);
        chk(32'(converter_enable_o), 32'h0);
        chk(32'(rail_tie_battery_o), 32'h1);
        wr(ADDR_CFG, 8'h02);
        repeat (3) @(negedge clk_sys_i);
        chk(32'(rail_tie_battery_o), 32'h0);
        wr(ADDR_CFG, 8'h00);
        sleep_mode_i <= 1'h0;
        period(p);
        period(p);
        chk(32'(p), 32'd104);
        wr(ADDR_CFG, 8'h60);
        period(p);
        period(p);
        chk(32'(p), 32'd104);
        for (int c = 0; c < 4; c++) begin
            // odd codes also invert the divider output; the period must not change
            wr(ADDR_CFG, 8'((c << 5) | ((c & 1) << 3) | 1));
            period(p);
            period(p);
            chk(32'(p), 32'(2 << c));
        end
        rd(ADDR_STAT, 32'h7);
        wr(ADDR_CFG, 8'h00);
        for (int c = 0; c < 4; c++) begin
            // minimum width in 4 ns cycles: none, 20, 40, 80 ns
            e = (c == 0) ? 1 : (20 << (c - 1)) / 4;
            wr(ADDR_CTRL, 8'((c << 6) | 8'h21));
            pulse(8'(e), w, s);
            chk(32'(w), 32'(e));
            chk(32'(s), 32'h0);
            if (c > 0) begin
                pulse(8'(e - 1), w, s);
                chk(32'(w), 32'h0);
                chk(32'(s), 32'h1);
            end
        end
        converter_strap_pin_i <= 1'h0;
        resets(1'h0);
        chk(32'(converter_enable_o), 32'h1);
        resets(1'h1);
        chk(32'(converter_enable_o), 32'h0);
        rd(ADDR_STAT, 32'h0);
        complete_run();
    end

    initial begin
        #200000;
        n_errors++;
        complete_run();
    end
endmodule
`default_nettype wire
